/* pkg/fthsr_pkg.sv */
// ----------------------------------------
// Shared constants and types
// ----------------------------------------
package fthsr_pkg;
    localparam int ADDR_W = 8;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int FIFO_DEPTH = 4;
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
    localparam int CTRL_ALLOW_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam logic CTRL_ALLOW_RESET = 1'h1;
    localparam logic CTRL_HOLD_RESET = 1'h0;
    localparam int ST_SELECTED_BIT = 0;
    localparam int ST_ORDER_BIT = 1;
    localparam int ST_COUNT_LSB = 2;
    localparam int ST_WRITE_BIT = 4;
    localparam int ST_FULL_BIT = 5;
    localparam int ST_EMPTY_BIT = 6;
    localparam int ST_VALID_BIT = 7;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    typedef enum logic [1:0] {
        CYC_DESEL,
        CYC_READ,
        CYC_WRITE
    } fthsr_cycle_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lanes;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0] par;
    } fthsr_wr_entry_type;
endpackage : fthsr_pkg

/* hdl/fthsr_fifo.sv */
`timescale 1ns/1ns
module fthsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic full,
    output logic empty
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] store_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    logic push;
    logic pop;

    assign full = (count_r == CNT_FULL);
    assign empty = (count_r == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Storage is flops, so read data is a read-pointer mux of flop outputs
    assign out_data = store_r[rd_ptr_r];

    always_ff @(posedge clk) begin
        if (push) begin
            store_r[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : PTR_W'(wr_ptr_r + 1'b1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : PTR_W'(rd_ptr_r + 1'b1);
            end
            if (push && !pop) begin
                count_r <= CNT_W'(count_r + 1'b1);
            end else if (pop && !push) begin
                count_r <= CNT_W'(count_r - 1'b1);
            end
        end
    end
endmodule : fthsr_fifo

/* hdl/fthsr_io_ctrl.sv */
`timescale 1ns/1ns
module fthsr_io_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fthsr_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [fthsr_pkg::ADDR_W-1:0] addr_in,
    input wire logic clock_qualify_n,
    input wire logic write_request_n,
    input wire logic burst_advance_or_load,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic [fthsr_pkg::LANES-1:0] byte_lane_write_select_n,
    input wire logic output_enable_n,
    input wire logic burst_order_strap,
    input wire logic strap_driven,
    input wire logic [fthsr_pkg::DATA_W-1:0] dq_in,
    output logic [fthsr_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [fthsr_pkg::LANES-1:0] parity_lines_in,
    output logic [fthsr_pkg::LANES-1:0] parity_lines_out,
    output logic parity_lines_oe,
    output logic write_stall
);
    localparam int DEPTH = 2 ** fthsr_pkg::ADDR_W;
    localparam int ENTRY_W = $bits(fthsr_pkg::fthsr_wr_entry_type);

    // ----------------------------------------
    // Burst address sequencing
    // ----------------------------------------
    // two low bits only
    function automatic logic [fthsr_pkg::ADDR_W-1:0] burst_addr(
        input logic [fthsr_pkg::ADDR_W-1:0] base,
        input logic [fthsr_pkg::BURST_W-1:0] cnt,
        input logic interleave
    );
        logic [fthsr_pkg::BURST_W-1:0] low;
        low = '0;
        if (interleave) begin
            low = base[fthsr_pkg::BURST_W-1:0] ^ cnt;
        end else begin
            low = fthsr_pkg::BURST_W'(base[fthsr_pkg::BURST_W-1:0] + cnt);
        end
        return {base[fthsr_pkg::ADDR_W-1:fthsr_pkg::BURST_W], low};
    endfunction : burst_addr

    fthsr_pkg::fthsr_cycle_type cyc_r;
    fthsr_pkg::fthsr_cycle_type cyc_nxt;
    logic [fthsr_pkg::ADDR_W-1:0] base_r;
    logic [fthsr_pkg::BURST_W-1:0] cnt_r;
    logic [fthsr_pkg::BURST_W-1:0] cnt_nxt;
    logic [fthsr_pkg::ADDR_W-1:0] read_addr_nxt;
    logic read_valid_r;
    logic order_r;
    logic strap_taken_r;
    logic ctrl_allow_r;
    logic ctrl_hold_r;
    logic [31:0] prdata_r;
    logic sel_now;
    logic load;
    logic edge_seen;
    logic qualified;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic fifo_full;
    logic fifo_empty;
    fthsr_pkg::fthsr_wr_entry_type wr_entry;
    fthsr_pkg::fthsr_wr_entry_type drain_entry;
    logic [ENTRY_W-1:0] drain_bits;
    // Lane index first, so each lane process owns its own slice of the array
    logic [fthsr_pkg::LANE_W-1:0] mem_data [fthsr_pkg::LANES][DEPTH];
    logic mem_par [fthsr_pkg::LANES][DEPTH];
    logic [fthsr_pkg::DATA_W-1:0] rd_data_r;
    logic [fthsr_pkg::LANES-1:0] rd_par_r;

    // ----------------------------------------
    // Edge qualification
    // ----------------------------------------
    // qualify gate
    assign edge_seen = !clock_qualify_n;
    // A full commit queue stretches the cycle rather than drop write data
    assign fifo_in_valid = edge_seen && (cyc_r == fthsr_pkg::CYC_WRITE);
    assign write_stall = fifo_in_valid && !fifo_in_ready;
    assign qualified = edge_seen && !write_stall;
    assign sel_now = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    assign load = !burst_advance_or_load;

    // ----------------------------------------
    // Cycle decode
    // ----------------------------------------
    always_comb begin
        cyc_nxt = cyc_r;
        cnt_nxt = cnt_r;
        read_addr_nxt = addr_in;
        if (load) begin
            cnt_nxt = fthsr_pkg::BURST_FIRST;
            read_addr_nxt = addr_in;
            if (!sel_now) begin
                cyc_nxt = fthsr_pkg::CYC_DESEL;
            end else if (!write_request_n) begin
                cyc_nxt = fthsr_pkg::CYC_WRITE;
            end else begin
                cyc_nxt = fthsr_pkg::CYC_READ;
            end
        end else begin
            cnt_nxt = fthsr_pkg::BURST_W'(cnt_r + fthsr_pkg::BURST_STEP);
            read_addr_nxt = burst_addr(base_r, cnt_nxt, order_r);
        end
    end

    // ----------------------------------------
    // Cycle state
    // ----------------------------------------
    // hold when unqualified
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_r <= fthsr_pkg::CYC_DESEL;
            cnt_r <= fthsr_pkg::BURST_FIRST;
            base_r <= '0;
        end else if (qualified) begin
            cyc_r <= cyc_nxt;
            cnt_r <= cnt_nxt;
            if (load && sel_now) begin
                base_r <= addr_in;
            end
        end
    end

    // ----------------------------------------
    // Output drive masking
    // ----------------------------------------
    // mask conditions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_valid_r <= 1'b0;
        end else if (qualified) begin
            read_valid_r <= (cyc_nxt == fthsr_pkg::CYC_READ) &&
                (cyc_r != fthsr_pkg::CYC_DESEL);
        end
    end

    assign dq_oe = !output_enable_n && read_valid_r && ctrl_allow_r;
    assign parity_lines_oe = dq_oe;

    // ----------------------------------------
    // Burst order strap
    // ----------------------------------------
    // undriven strap is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_taken_r <= 1'b0;
            order_r <= 1'b1;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            order_r <= strap_driven ? burst_order_strap : 1'b1;
        end
    end

    // ----------------------------------------
    // Write capture and commit queue
    // ----------------------------------------
    // capture on edge
    always_comb begin
        wr_entry.addr = burst_addr(base_r, cnt_r, order_r);
        wr_entry.lanes = ~byte_lane_write_select_n;
        wr_entry.data = dq_in;
        wr_entry.par = parity_lines_in;
    end

    // Software hold lets the queue fill, to exercise stretching
    assign fifo_out_ready = !ctrl_hold_r;
    assign drain_entry = fthsr_pkg::fthsr_wr_entry_type'(drain_bits);

    fthsr_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(fthsr_pkg::FIFO_DEPTH)
    ) u_commit_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(wr_entry),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(drain_bits),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // ----------------------------------------
    // Storage array and read return
    // ----------------------------------------
    // Reads do not see words still queued; controller must avoid that
    genvar lane;
    generate
        for (lane = 0; lane < fthsr_pkg::LANES; lane++) begin : g_lane
            always_ff @(posedge pclk) begin
                if (fifo_out_valid && fifo_out_ready && drain_entry.lanes[lane]) begin
                    mem_data[lane][drain_entry.addr] <=
                        drain_entry.data[lane*fthsr_pkg::LANE_W +: fthsr_pkg::LANE_W];
                    mem_par[lane][drain_entry.addr] <= drain_entry.par[lane];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rd_data_r[lane*fthsr_pkg::LANE_W +: fthsr_pkg::LANE_W] <= '0;
                    rd_par_r[lane] <= 1'b0;
                end else if (qualified) begin
                    rd_data_r[lane*fthsr_pkg::LANE_W +: fthsr_pkg::LANE_W] <=
                        mem_data[lane][read_addr_nxt];
                    rd_par_r[lane] <= mem_par[lane][read_addr_nxt];
                end
            end
        end
    endgenerate

    assign dq_out = rd_data_r;
    assign parity_lines_out = rd_par_r;

    // ----------------------------------------
    // APB register slave
    // ----------------------------------------
    logic apb_setup;
    logic apb_write;
    logic hit;

    assign apb_setup = psel && !penable;
    assign hit = (paddr == fthsr_pkg::REG_CTRL) || (paddr == fthsr_pkg::REG_STATUS);
    assign apb_write = psel && penable && pwrite && (paddr == fthsr_pkg::REG_CTRL);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_allow_r <= fthsr_pkg::CTRL_ALLOW_RESET;
            ctrl_hold_r <= fthsr_pkg::CTRL_HOLD_RESET;
        end else if (apb_write && pstrb[0]) begin
            ctrl_allow_r <= pwdata[fthsr_pkg::CTRL_ALLOW_BIT];
            ctrl_hold_r <= pwdata[fthsr_pkg::CTRL_HOLD_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= fthsr_pkg::WORD_ZERO;
        end else if (apb_setup) begin
            prdata_r <= fthsr_pkg::WORD_ZERO;
            if (!pwrite && paddr == fthsr_pkg::REG_CTRL) begin
                prdata_r[fthsr_pkg::CTRL_ALLOW_BIT] <= ctrl_allow_r;
                prdata_r[fthsr_pkg::CTRL_HOLD_BIT] <= ctrl_hold_r;
            end else if (!pwrite && paddr == fthsr_pkg::REG_STATUS) begin
                prdata_r[fthsr_pkg::ST_SELECTED_BIT] <= (cyc_r != fthsr_pkg::CYC_DESEL);
                prdata_r[fthsr_pkg::ST_ORDER_BIT] <= order_r;
                prdata_r[fthsr_pkg::ST_COUNT_LSB +: fthsr_pkg::BURST_W] <= cnt_r;
                prdata_r[fthsr_pkg::ST_WRITE_BIT] <= (cyc_r == fthsr_pkg::CYC_WRITE);
                prdata_r[fthsr_pkg::ST_FULL_BIT] <= fifo_full;
                prdata_r[fthsr_pkg::ST_EMPTY_BIT] <= fifo_empty;
                prdata_r[fthsr_pkg::ST_VALID_BIT] <= read_valid_r;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_oe_off;
        output_enable_n |-> !dq_oe && !parity_lines_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driving while enable high");

    property p_oe_on;
        !output_enable_n && read_valid_r && ctrl_allow_r |-> dq_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("not driving read data");

    property p_write_mask;
        cyc_r != fthsr_pkg::CYC_READ |-> !dq_oe;
    endproperty
    a_write_mask: assert property (p_write_mask) else $error("drive outside read");

    property p_emerge;
        qualified && cyc_r == fthsr_pkg::CYC_DESEL && sel_now && load |=> !dq_oe;
    endproperty
    a_emerge: assert property (p_emerge) else $error("drive on first clock");

    property p_hold;
        !qualified |=> $stable(cyc_r) && $stable(cnt_r) && $stable(base_r);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while held");

    property p_load;
        qualified && load && sel_now |=> base_r == $past(addr_in) && cnt_r == '0;
    endproperty
    a_load: assert property (p_load) else $error("address not loaded");

    property p_advance;
        qualified && !load |=> cnt_r == fthsr_pkg::BURST_W'($past(cnt_r) + 2'h1);
    endproperty
    a_advance: assert property (p_advance) else $error("counter not stepped");

    property p_capture;
        fifo_in_valid && fifo_in_ready |=> !fifo_empty;
    endproperty
    a_capture: assert property (p_capture) else $error("write data lost");

    property p_parity;
        parity_lines_oe == dq_oe;
    endproperty
    a_parity: assert property (p_parity) else $error("parity drive differs");

    property p_strap;
        strap_taken_r ##1 strap_taken_r |-> $stable(order_r);
    endproperty
    a_strap: assert property (p_strap) else $error("burst order changed");

    property p_read_cycle;
        read_valid_r |-> cyc_r == fthsr_pkg::CYC_READ;
    endproperty
    a_read_cycle: assert property (p_read_cycle) else $error("valid outside read");
endmodule : fthsr_io_ctrl

/* dv/fthsr_ctrl_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Controller side of the memory pins
// ----------------------------------------
module fthsr_ctrl_model (
    input wire logic pclk,
    input wire logic write_stall,
    input wire logic [35:0] bus_in,
    input wire logic [1:0] bus_oe,
    output logic clock_qualify_n,
    output logic write_request_n,
    output logic burst_advance_or_load,
    output logic [2:0] chip_sel,
    output logic output_enable_n,
    output logic [7:0] addr,
    output logic [3:0] lanes_n,
    output logic [35:0] drv_data,
    output logic drv_en
);
    logic [35:0] seen_bus;
    logic [1:0] seen_oe;
    logic seen_stall;
    int hang = 0;

    initial begin
        clock_qualify_n = 1'h1;
        write_request_n = 1'h1;
        burst_advance_or_load = 1'h0;
        chip_sel = 3'h7;
        output_enable_n = 1'h1;
        addr = 8'h00;
        lanes_n = 4'hF;
        drv_data = 36'h000000000;
        drv_en = 1'h0;
    end

    // Control bits {oe_n, qualify_n, write_n, advance, select}; call just after a rising edge
    task automatic cyc(input logic [4:0] c, input logic [7:0] a, input logic [3:0] ln,
                       input logic [35:0] d, input logic de);
        output_enable_n <= c[4];
        clock_qualify_n <= c[3];
        write_request_n <= c[2];
        burst_advance_or_load <= c[1];
        chip_sel <= c[0] ? 3'h2 : 3'h7;
        addr <= a;
        lanes_n <= ln;
        drv_en <= de;
        // Released lines toggle so stale data cannot pass for a read
        drv_data <= de ? d : ~drv_data;
        @(negedge pclk);
        seen_bus = bus_in;
        seen_oe = bus_oe;
        seen_stall = write_stall;
        // A refused data beat is held until the stall drops
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (write_stall !== 1'h1) break;
            if (i == 39) hang++;
        end
    endtask : cyc
endmodule : fthsr_ctrl_model

/* dv/flow_through_sram_io_control_test.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module flow_through_sram_io_control_test;
    localparam logic [4:0] RD = 5'h05;
    localparam logic [4:0] WR = 5'h01;
    localparam logic [4:0] ADV = 5'h07;
    localparam logic [4:0] DES = 5'h04;
    localparam logic [4:0] HLD = 5'h0D;
    localparam logic [4:0] RDX = 5'h15;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [fthsr_pkg::PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, r, dq_out;
    logic cqn, wrn, adv, oen, de, strap, sdrv, dq_oe, par_oe, stall;
    logic [2:0] cs;
    logic [7:0] addr;
    logic [3:0] ln, par_out;
    logic [35:0] drv, bus;
    int fail_count = 0;
    int n_compared = 0;

    // ----------------------------------------
    // Shared data lines and instances
    // ----------------------------------------
    assign bus[31:0] = dq_oe ? dq_out : drv[31:0];
    assign bus[35:32] = par_oe ? par_out : drv[35:32];
    fthsr_io_ctrl uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .addr_in(addr), .clock_qualify_n(cqn), .write_request_n(wrn),
        .burst_advance_or_load(adv), .chip_select_a_n(cs[0]), .chip_select_b(cs[1]),
        .chip_select_c_n(cs[2]), .byte_lane_write_select_n(ln), .output_enable_n(oen),
        .burst_order_strap(strap), .strap_driven(sdrv), .dq_in(bus[31:0]), .dq_out(dq_out),
        .dq_oe(dq_oe), .parity_lines_in(bus[35:32]), .parity_lines_out(par_out),
        .parity_lines_oe(par_oe), .write_stall(stall)
    );
    fthsr_ctrl_model m (
        .pclk(pclk), .write_stall(stall), .bus_in(bus), .bus_oe({dq_oe, par_oe}),
        .clock_qualify_n(cqn), .write_request_n(wrn), .burst_advance_or_load(adv),
        .chip_sel(cs), .output_enable_n(oen), .addr(addr), .lanes_n(ln), .drv_data(drv),
        .drv_en(de)
    );

    // ----------------------------------------
    // Bus and pin helpers
    // ----------------------------------------
    task automatic print_verdict;
        fail_count += m.hang;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic apb(input logic w, input logic [fthsr_pkg::PADDR_W-1:0] a,
                       input logic [31:0] d, output logic [31:0] rv, output logic er);
        int i;
        // Back to back calls let an edge pass, so psel is set once per step
        if (psel) @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        if (pready !== 1'h1) begin
            fail_count++;
            print_verdict();
        end
        rv = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rd(input logic [4:0] c, input logic [7:0] a);
        m.cyc(c, a, 4'hF, 36'h000000000, 1'h0);
    endtask : rd

    // Filler read rides in the data cycle, a spare cycle lets the commit drain
    task automatic wr(input logic [7:0] a, input logic [35:0] d, input logic [3:0] ln);
        m.cyc(WR, a, 4'hF, 36'h000000000, 1'h0);
        m.cyc(RD, 8'hFF, ln, d, 1'h1);
        `CHK("oe in write", 2'h0, m.seen_oe)
        rd(RD, 8'hFF);
    endtask : wr

    task automatic burst(input logic [1:0] b, input logic il);
        logic [1:0] k;
        rd(RD, {6'h0C, b});
        for (int j = 0; j < 4; j++) begin
            k = il ? (b ^ j[1:0]) : (b + j[1:0]);
            rd(j < 3 ? ADV : RD, 8'hFF);
            `CHK("burst", 36'h05A5A5A00 + {34'h0, k}, m.seen_bus)
        end
    endtask : burst

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        apb(1'h0, fthsr_pkg::REG_CTRL, 32'h0, r, e);
        `CHK("ctrl", 32'h00000001, r)
        apb(1'h0, fthsr_pkg::REG_STATUS, 32'h0, r, e);
        `CHK("order", 1'h1, r[fthsr_pkg::ST_ORDER_BIT])
        apb(1'h0, 12'h008, 32'h0, r, e);
        `CHK("slverr", 1'h1, e)
        `CHK("unmapped", 32'h00000000, r)
        $display("test regs done");
    endtask : t_regs

    task automatic t_data;
        wr(8'h12, 36'h51234ABCD, 4'h0);
        wr(8'h20, 36'hFFFFFFFFF, 4'h0);
        wr(8'h20, 36'h000000000, 4'hA);
        rd(RD, 8'h12);
        rd(RD, 8'h20);
        `CHK("read", 36'h51234ABCD, m.seen_bus)
        `CHK("read oe", 2'h3, m.seen_oe)
        rd(RD, 8'hFF);
        `CHK("lanes", 36'hAFF00FF00, m.seen_bus)
        for (int i = 0; i < 4; i++) wr({6'h0C, i[1:0]}, 36'h05A5A5A00 + {34'h0, i[1:0]}, 4'h0);
        burst(2'h1, 1'h1);
        $display("test data done");
    endtask : t_data

    task automatic t_oe;
        rd(RD, 8'h12);
        rd(RDX, 8'hFF);
        `CHK("oe high", 2'h0, m.seen_oe)
        rd(DES, 8'h00);
        rd(RD, 8'h12);
        `CHK("deselected", 2'h0, m.seen_oe)
        rd(RD, 8'h12);
        `CHK("first after", 2'h0, m.seen_oe)
        rd(RD, 8'h12);
        `CHK("reread", 36'h51234ABCD, m.seen_bus)
        rd(HLD, 8'h20);
        rd(HLD, 8'h20);
        rd(RD, 8'hFF);
        `CHK("held", 36'h51234ABCD, m.seen_bus)
        apb(1'h1, fthsr_pkg::REG_CTRL, 32'h0, r, e);
        rd(RD, 8'h12);
        rd(RD, 8'hFF);
        `CHK("no allow", 2'h0, m.seen_oe)
        $display("test oe done");
    endtask : t_oe

    // Hold stops the drain so the fifth beat is refused until released
    task automatic t_fifo;
        apb(1'h1, fthsr_pkg::REG_CTRL, 32'h3, r, e);
        for (int i = 0; i < 4; i++) wr(8'h40 + i[7:0], 36'h077770000 + {32'h0, i[3:0]}, 4'h0);
        apb(1'h0, fthsr_pkg::REG_STATUS, 32'h0, r, e);
        `CHK("full", 1'h1, r[fthsr_pkg::ST_FULL_BIT])
        m.cyc(WR, 8'h44, 4'hF, 36'h000000000, 1'h0);
        fork
            m.cyc(RD, 8'hFF, 4'h0, 36'h077770004, 1'h1);
            begin
                repeat (4) @(posedge pclk);
                apb(1'h1, fthsr_pkg::REG_CTRL, 32'h1, r, e);
            end
        join
        `CHK("stall", 1'h1, m.seen_stall)
        repeat (6) rd(RD, 8'hFF);
        rd(RD, 8'h44);
        rd(RD, 8'h40);
        `CHK("beat5", 36'h077770004, m.seen_bus)
        rd(RD, 8'hFF);
        `CHK("beat1", 36'h077770000, m.seen_bus)
        $display("test fifo done");
    endtask : t_fifo

    task automatic t_linear;
        // Park the pins so no request lands on the edge that releases reset
        rd(HLD, 8'hFF);
        presetn <= 1'h0;
        strap <= 1'h0;
        sdrv <= 1'h1;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, fthsr_pkg::REG_STATUS, 32'h0, r, e);
        `CHK("linear", 1'h0, r[fthsr_pkg::ST_ORDER_BIT])
        rd(RD, 8'hFF);
        burst(2'h3, 1'h0);
        $display("test linear done");
    endtask : t_linear

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        strap = 1'h0;
        sdrv = 1'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        t_regs();
        t_data();
        t_oe();
        t_fifo();
        t_linear();
        print_verdict();
    end
endmodule : flow_through_sram_io_control_test
